//--- rtl/asr_pkg.sv
package asr_pkg;

    // Oscillator cycles per serial bit, for both receive and transmit.
    localparam int ASR_BIT_DIV = 64;
    // Address pins are latched this many cycles after the start bit ends.
    localparam int ASR_ADDR_LATCH_CYC = 31;
    localparam int ASR_DATA_BITS = 8;
    localparam int ASR_CMD_BITS = 7;
    // Start, eight data, parity and stop.
    localparam int ASR_FRAME_BITS = 11;
    // Bit index of the stop bit within a receive frame.
    localparam int ASR_STOP_IDX = 10;

    localparam int ASR_CLK_PERIOD_NS = 25;
    localparam int ASR_RESET_MIN_NS = 700;
    localparam int ASR_RESET_MIN_CYC = (ASR_RESET_MIN_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;

    // Receive line idles high; the transmit pin idles low because it is inverted.
    localparam logic ASR_RX_IDLE_LVL = 1'b1;
    localparam logic ASR_TX_IDLE_LVL = 1'b0;
    localparam logic ASR_START_LVL = 1'b0;
    localparam logic ASR_STOP_LVL = 1'b1;
    localparam logic ASR_FLAG_ADDR = 1'b1;

    typedef enum logic [2:0] {
        ASR_RX_IDLE = 3'h1,
        ASR_RX_BITS = 3'h2,
        ASR_RX_HOLD = 3'h4
    } asr_rx_t;

    typedef enum logic [2:0] {
        ASR_TX_IDLE = 3'h1,
        ASR_TX_WAIT = 3'h2,
        ASR_TX_SEND = 3'h4
    } asr_tx_t;

endpackage : asr_pkg

//--- rtl/asr_responder.sv
`timescale 1ns/100ps
// Operation
// - A received start bit starts a receive bit clock of oscillator divided by 64.
// - Every received bit is sampled in the middle of its bit period.
// - Eight data bits follow the start bit; seven are compared with station address.
// - Station address pins are latched 31 cycles after the start bit ends.
// - Eighth data bit high marks an address word, low marks a command word.
// - An even parity bit is checked, then a stop bit is received.
// - A completed address word matching the station address pulses the match output.
// - The end of the command word queues it; the command strobe pulses once CMD_READY is high.
// - The command strobe is exactly one oscillator cycle wide.
// - The seven command bits of the second word appear on the command outputs.
// - A rising edge on the send input begins transmission.
// - Send is accepted only after an address has been received.
// - Two eleven-bit words are sent, from the first and second input bytes.
// - First byte is captured one clock before the first start bit begins.
// - Second byte is captured at the start of the first start bit.
// - Transmit output is the logical inverse of the receive line polarity.
// - Transmission starts between one half and one and a half bits after send, or two bits after a send on the last bit-clock cycle.
module asr_responder
    import asr_pkg::*;
#(
    parameter int BIT_DIV = ASR_BIT_DIV,
    parameter int ADDR_LATCH_CYC = ASR_ADDR_LATCH_CYC,
    parameter int CMD_W = ASR_CMD_BITS
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic SERIAL_RX_IN,
    input wire logic [ASR_CMD_BITS-1:0] STATION_ADDR_IN,
    input wire logic SEND_IN,
    input wire logic [ASR_DATA_BITS-1:0] TX_FIRST_BYTE_IN,
    input wire logic [ASR_DATA_BITS-1:0] TX_SECOND_BYTE_IN,
    input wire logic CMD_READY,
    output logic SERIAL_TX_OUT,
    output logic ADDR_MATCH_PULSE,
    output logic CMD_STROBE,
    output logic [CMD_W-1:0] CMD_WORD_OUT
);

    localparam int PH_W = $clog2(BIT_DIV);
    localparam logic [PH_W-1:0] PH_ZERO = '0;
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(BIT_DIV - 1);
    localparam logic [PH_W-1:0] PH_MID = PH_W'(BIT_DIV / 2 - 1);
    localparam logic [PH_W-1:0] PH_LATE = PH_W'(BIT_DIV - BIT_DIV / 2);
    localparam logic [PH_W-1:0] PH_ADDR = PH_W'(ADDR_LATCH_CYC);
    localparam logic [3:0] BIT_START = 4'h0;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_STOP = 4'(ASR_STOP_IDX);
    localparam logic [3:0] BIT_FRAME = 4'(ASR_FRAME_BITS);

    typedef struct packed {
        logic [2:0] rx_sync;
        logic rx_f;
        logic [2:0] snd_sync;
        logic snd_f;
        asr_rx_t rx_st;
        logic [PH_W-1:0] rx_ph;
        logic [3:0] rx_bit;
        logic [ASR_DATA_BITS:0] rx_sh;
        logic [ASR_CMD_BITS-1:0] addr;
        logic addr_ok;
        logic armed;
        logic match_p;
        asr_tx_t tx_st;
        logic [PH_W-1:0] tx_ph;
        logic skip;
        logic tx_word;
        logic [3:0] tx_bit;
        logic [ASR_FRAME_BITS-1:0] tx_sh;
        logic [ASR_DATA_BITS-1:0] second;
        logic tx_out;
        logic hv;
        logic sv;
        logic gap;
        logic [CMD_W-1:0] head;
        logic [CMD_W-1:0] skid;
    } asr_state_t;

    localparam asr_state_t ASR_RESET_STATE = '{
        rx_sync: {3{ASR_RX_IDLE_LVL}},
        rx_f: ASR_RX_IDLE_LVL,
        snd_sync: 3'h0,
        snd_f: 1'b0,
        rx_st: ASR_RX_IDLE,
        rx_ph: '0,
        rx_bit: 4'h0,
        rx_sh: '0,
        addr: '0,
        addr_ok: 1'b0,
        armed: 1'b0,
        match_p: 1'b0,
        tx_st: ASR_TX_IDLE,
        tx_ph: '0,
        skip: 1'b0,
        tx_word: 1'b0,
        tx_bit: 4'h0,
        tx_sh: '0,
        second: '0,
        tx_out: ASR_TX_IDLE_LVL,
        hv: 1'b0,
        sv: 1'b0,
        gap: 1'b0,
        head: '0,
        skid: '0
    };

    asr_state_t st_q;
    asr_state_t st_d;

    function automatic logic [ASR_FRAME_BITS-1:0] make_frame(input logic [ASR_DATA_BITS-1:0] data);
        make_frame = {ASR_STOP_LVL, ^data, data, ASR_START_LVL};
    endfunction : make_frame

    function automatic logic [PH_W-1:0] ph_step(input logic [PH_W-1:0] ph);
        if (ph == PH_LAST) begin
            ph_step = PH_ZERO;
        end else begin
            ph_step = PH_W'(ph + 1'b1);
        end
    endfunction : ph_step

    // A pin counts as changed only once the second and third stages agree, which rejects one-cycle glitches.
    function automatic logic settle(input logic [2:0] sync, input logic prev);
        if (sync[1] == sync[2]) begin
            settle = sync[2];
        end else begin
            settle = prev;
        end
    endfunction : settle

    always_comb begin
        logic buf_ready;
        logic pop;
        logic push;
        logic good;
        logic send_rise;
        logic [ASR_FRAME_BITS-1:0] frame;
        logic [CMD_W-1:0] cmd_in;
        logic arm_new;

        st_d = st_q;
        push = 1'b0;
        send_rise = 1'b0;
        arm_new = 1'b0;
        good = 1'b0;
        frame = st_q.tx_sh;
        cmd_in = CMD_W'(st_q.rx_sh[ASR_CMD_BITS-1:0]);
        buf_ready = ~(st_q.hv & st_q.sv);
        pop = st_q.hv & CMD_READY & ~st_q.gap;

        // Pin inputs settle through three flops; a change counts once the last two agree.
        st_d.rx_sync = {st_q.rx_sync[1:0], SERIAL_RX_IN};
        st_d.snd_sync = {st_q.snd_sync[1:0], SEND_IN};
        st_d.rx_f = settle(st_q.rx_sync, st_q.rx_f);
        st_d.snd_f = settle(st_q.snd_sync, st_q.snd_f);
        send_rise = st_d.snd_f & ~st_q.snd_f;
        st_d.match_p = 1'b0;
        // A popped word leaves one quiet cycle, so two queued words never merge into one wide strobe.
        st_d.gap = pop;

        // Receiver.
        case (st_q.rx_st)
            ASR_RX_IDLE: begin
                // A full command buffer holds off the next word rather than drop one later.
                if (st_q.rx_f == ASR_START_LVL) begin
                    st_d.rx_st = buf_ready ? ASR_RX_BITS : ASR_RX_HOLD;
                    st_d.rx_ph = PH_ZERO;
                    st_d.rx_bit = BIT_START;
                end
            end
            ASR_RX_HOLD: begin
                // Time the ignored word out in full; a high data bit must not pass for line idle.
                st_d.rx_ph = ph_step(st_q.rx_ph);
                if (st_q.rx_ph == PH_LAST) begin
                    st_d.rx_bit = 4'(st_q.rx_bit + 1'b1);
                end
                if (st_q.rx_ph == PH_MID) begin
                    if (st_q.rx_bit == BIT_STOP) begin
                        st_d.rx_st = ASR_RX_IDLE;
                    end else if (st_q.rx_bit == BIT_START && st_q.rx_f != ASR_START_LVL) begin
                        st_d.rx_st = ASR_RX_IDLE;
                    end
                end
            end
            ASR_RX_BITS: begin
                st_d.rx_ph = ph_step(st_q.rx_ph);
                if (st_q.rx_ph == PH_LAST) begin
                    st_d.rx_bit = 4'(st_q.rx_bit + 1'b1);
                end
                // Address pins are read without synchronisers, so they must stay still while a word arrives.
                if (st_q.rx_bit == BIT_FIRST && st_q.rx_ph == PH_ADDR) begin
                    st_d.addr = STATION_ADDR_IN;
                end
                if (st_q.rx_ph == PH_MID) begin
                    if (st_q.rx_bit == BIT_START) begin
                        if (st_q.rx_f != ASR_START_LVL) begin
                            // A glitch shorter than half a bit is not a start bit.
                            st_d.rx_st = ASR_RX_IDLE;
                        end
                    end else if (st_q.rx_bit != BIT_STOP) begin
                        st_d.rx_sh = {st_q.rx_f, st_q.rx_sh[ASR_DATA_BITS:1]};
                    end else begin
                        st_d.rx_st = ASR_RX_IDLE;
                        good = (st_q.rx_f == ASR_STOP_LVL) && !(^st_q.rx_sh);
                        if (st_q.rx_sh[ASR_DATA_BITS-1] == ASR_FLAG_ADDR) begin
                            good = good && (st_q.rx_sh[ASR_CMD_BITS-1:0] == st_q.addr);
                            st_d.match_p = good;
                            st_d.addr_ok = good;
                            st_d.armed = good;
                            arm_new = good;
                        end else begin
                            push = good && st_q.addr_ok;
                            st_d.addr_ok = 1'b0;
                            if (!good) begin
                                st_d.armed = 1'b0;
                            end
                        end
                    end
                end
            end
            default: begin
                st_d.rx_st = ASR_RX_IDLE;
            end
        endcase

        // Two-entry command buffer; the head register drives the command pins.
        if (pop && push) begin
            st_d.head = st_q.sv ? st_q.skid : cmd_in;
            st_d.skid = cmd_in;
        end else if (pop) begin
            st_d.head = st_q.skid;
            st_d.hv = st_q.sv;
            st_d.sv = 1'b0;
        end else if (push) begin
            if (!st_q.hv) begin
                st_d.head = cmd_in;
                st_d.hv = 1'b1;
            end else begin
                st_d.skid = cmd_in;
                st_d.sv = 1'b1;
            end
        end

        // Transmitter on a free-running bit clock.
        st_d.tx_ph = ph_step(st_q.tx_ph);
        case (st_q.tx_st)
            ASR_TX_IDLE: begin
                if (send_rise && st_q.armed) begin
                    // An address match in this same cycle arms the next exchange and must not be lost.
                    st_d.armed = arm_new;
                    // Less than half a bit left means one more bit of delay.
                    st_d.skip = (st_q.tx_ph >= PH_LATE);
                    st_d.tx_st = ASR_TX_WAIT;
                end
            end
            ASR_TX_WAIT: begin
                if (st_q.tx_ph == PH_LAST) begin
                    if (st_q.skip) begin
                        st_d.skip = 1'b0;
                    end else begin
                        // Byte pins are read directly and must be steady at their capture edges.
                        st_d.tx_sh = make_frame(TX_FIRST_BYTE_IN);
                        st_d.tx_bit = BIT_START;
                        st_d.tx_word = 1'b0;
                        st_d.tx_st = ASR_TX_SEND;
                    end
                end
            end
            ASR_TX_SEND: begin
                if (st_q.tx_ph == PH_ZERO) begin
                    if (st_q.tx_bit == BIT_START && !st_q.tx_word) begin
                        st_d.second = TX_SECOND_BYTE_IN;
                    end
                    if (st_q.tx_bit == BIT_FRAME) begin
                        frame = make_frame(st_q.second);
                    end
                    if (st_q.tx_bit == BIT_FRAME && st_q.tx_word) begin
                        st_d.tx_out = ASR_TX_IDLE_LVL;
                        st_d.tx_st = ASR_TX_IDLE;
                    end else begin
                        st_d.tx_out = ~frame[0];
                        st_d.tx_sh = {1'b0, frame[ASR_FRAME_BITS-1:1]};
                        st_d.tx_bit = (st_q.tx_bit == BIT_FRAME) ? BIT_FIRST : 4'(st_q.tx_bit + 1'b1);
                        st_d.tx_word = st_q.tx_word | (st_q.tx_bit == BIT_FRAME);
                    end
                end
            end
            default: begin
                st_d.tx_st = ASR_TX_IDLE;
            end
        endcase
    end

    // The block assumes the reset pulse meets the minimum width; no stretching is done here.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= ASR_RESET_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    assign SERIAL_TX_OUT = st_q.tx_out;
    assign ADDR_MATCH_PULSE = st_q.match_p;
    // With the consumer ready, each word gives one strobe cycle followed by a quiet one.
    assign CMD_STROBE = st_q.hv & CMD_READY & ~st_q.gap;
    assign CMD_WORD_OUT = st_q.head;

endmodule : asr_responder

//--- sim/asr_responder_sva.sv
`timescale 1ns/100ps
module asr_responder_sva #(
    parameter int BIT_DIV = 64
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic SERIAL_RX_IN,
    input wire logic SEND_IN,
    input wire logic CMD_READY,
    input wire logic SERIAL_TX_OUT,
    input wire logic ADDR_MATCH_PULSE,
    input wire logic CMD_STROBE
);
    logic tx_prev_q;
    logic seen_q;
    int gap_q;
    int since_match_q;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // Every transmit edge must fall on the free-running bit grid, so the gap is counted here.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_prev_q <= 1'b0;
            seen_q <= 1'b0;
            gap_q <= 0;
            since_match_q <= 16 * BIT_DIV;
        end else begin
            if (ADDR_MATCH_PULSE) begin
                since_match_q <= 0;
            end else if (since_match_q < 16 * BIT_DIV) begin
                since_match_q <= since_match_q + 1;
            end
            tx_prev_q <= SERIAL_TX_OUT;
            seen_q <= seen_q | (SERIAL_TX_OUT != tx_prev_q);
            gap_q <= (SERIAL_TX_OUT != tx_prev_q) ? 1 : gap_q + 1;
        end
    end
    a_match_single: assert property (ADDR_MATCH_PULSE |=> !ADDR_MATCH_PULSE)
        else $error("match pulse longer than one cycle");
    a_strobe_ready: assert property (CMD_STROBE |-> CMD_READY)
        else $error("strobe without ready");
    a_strobe_single: assert property (CMD_STROBE |=> !CMD_STROBE)
        else $error("strobe wider than one cycle");
    a_match_at_stop: assert property ($rose(ADDR_MATCH_PULSE) |-> $past(SERIAL_RX_IN, 2))
        else $error("match pulse outside stop bit");
    a_strobe_at_stop: assert property ($rose(CMD_STROBE) && $past(CMD_READY) && !$past(CMD_STROBE, 2) |-> $past(SERIAL_RX_IN, 2))
        else $error("strobe outside stop bit");
    a_word_kind_apart: assert property ($rose(CMD_STROBE) && $past(CMD_READY) |-> !ADDR_MATCH_PULSE)
        else $error("match and strobe from one word");
    a_cmd_after_addr: assert property ($rose(CMD_STROBE) && $past(CMD_READY) && !$past(CMD_STROBE, 2) |-> since_match_q >= 11 * BIT_DIV - 2 && since_match_q <= 11 * BIT_DIV)
        else $error("command strobe not one word after the match pulse");
    a_tx_bit_grid: assert property (seen_q && SERIAL_TX_OUT != tx_prev_q |-> gap_q % BIT_DIV == 0)
        else $error("transmit edge off the bit grid");
    a_tx_after_send: assert property (!tx_prev_q && SERIAL_TX_OUT && gap_q > 2 * BIT_DIV |-> $past(SEND_IN, 4))
        else $error("transmission without send");
    a_reset_quiet: assert property (disable iff (1'b0) !RESET_N |-> !SERIAL_TX_OUT && !ADDR_MATCH_PULSE && !CMD_STROBE)
        else $error("outputs active in reset");
endmodule : asr_responder_sva
bind asr_responder asr_responder_sva #(.BIT_DIV(BIT_DIV)) asr_responder_sva_inst (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .SERIAL_RX_IN(SERIAL_RX_IN), .SEND_IN(SEND_IN),
    .CMD_READY(CMD_READY), .SERIAL_TX_OUT(SERIAL_TX_OUT), .ADDR_MATCH_PULSE(ADDR_MATCH_PULSE),
    .CMD_STROBE(CMD_STROBE)
);

//--- sim/asr_master_model.sv
`timescale 1ns/100ps
module asr_master_model #(
    parameter int BD = 8
) (
    input wire logic clk,
    output logic rx_line,
    input wire logic tx_line
);
    initial rx_line = 1'b1;
    // A set bad flag flips the parity so the responder sees a broken word.
    task automatic send_word(input logic [7:0] d, input logic bad);
        logic [10:0] f;
        f = {1'b1, ^d ^ bad, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rx_line <= f[i];
            repeat (BD) @(posedge clk);
        end
    endtask : send_word
    // The transmit pin is inverted, so each bit is flipped back; sampling on the falling edge avoids races.
    task automatic recv_word(output logic [7:0] d, output logic ok);
        logic [9:0] b;
        int n;
        n = 0;
        while (tx_line !== 1'b1 && n < 64 * BD) begin
            @(negedge clk);
            n++;
        end
        repeat (BD / 2) @(negedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BD) @(negedge clk);
            b[i] = ~tx_line;
        end
        d = b[7:0];
        ok = (n < 64 * BD) && (^b[8:0] == 1'b0) && b[9];
    endtask : recv_word
endmodule : asr_master_model

//--- sim/tb.sv
`timescale 1ns/100ps
module tb;
    import asr_pkg::*;
    localparam int BD = 8;
    typedef struct {logic [6:0] st; logic [6:0] ad; logic [6:0] cm; logic [1:0] bad; logic [7:0] em; logic [7:0] es;} asr_row_t;
    asr_row_t rows[5] = '{'{7'h2a, 7'h2a, 7'h55, 2'h0, 8'h1, 8'h1}, '{7'h2a, 7'h2b, 7'h11, 2'h0, 8'h0, 8'h0},
        '{7'h7f, 7'h7f, 7'h00, 2'h0, 8'h1, 8'h1}, '{7'h00, 7'h00, 7'h22, 2'h1, 8'h0, 8'h0},
        '{7'h01, 7'h01, 7'h7f, 2'h2, 8'h1, 8'h0}};
    logic clock, reset_n, send, ready, rx, tx, match, strobe, ok1, ok2;
    logic [6:0] station, cmd;
    logic [7:0] b1, b2, d1, d2, n_match, n_strobe, n_tx;
    logic [6:0] cmds[$];
    int num_errors = 0, cmp_count = 0, k;
    asr_responder #(.BIT_DIV(BD), .ADDR_LATCH_CYC(3)) asr_responder_inst (.CLOCK(clock), .RESET_N(reset_n),
        .SERIAL_RX_IN(rx), .STATION_ADDR_IN(station), .SEND_IN(send), .TX_FIRST_BYTE_IN(b1),
        .TX_SECOND_BYTE_IN(b2), .CMD_READY(ready), .SERIAL_TX_OUT(tx), .ADDR_MATCH_PULSE(match),
        .CMD_STROBE(strobe), .CMD_WORD_OUT(cmd));
    asr_master_model #(.BD(BD)) master_inst (.clk(clock), .rx_line(rx), .tx_line(tx));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (match === 1'b1) n_match++;
        if (tx === 1'b1) n_tx++;
        if (strobe === 1'b1) begin
            n_strobe++;
            cmds.push_back(cmd);
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic pair(input logic [6:0] a, input logic [6:0] c, input logic [1:0] bad);
        n_match = 8'h0;
        n_strobe = 8'h0;
        cmds = {};
        master_inst.send_word({1'b1, a}, bad[0]);
        master_inst.send_word({1'b0, c}, bad[1]);
        repeat (4 * BD) @(posedge clock);
    endtask : pair
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        #(25 * 40000);
        num_errors++;
        print_verdict();
    end
    initial begin
        reset_n = 1'b0;
        send = 1'b0;
        ready = 1'b1;
        station = 7'h00;
        b1 = 8'h00;
        b2 = 8'h00;
        n_tx = 8'h0;
        repeat (ASR_RESET_MIN_CYC) @(posedge clock);
        chk("reset outputs", 8'h00, {5'h00, tx, match, strobe});
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        send <= 1'b1;
        repeat (30 * BD) @(posedge clock);
        chk("unarmed transmit", 8'h00, n_tx);
        send <= 1'b0;
        $display("reset and unarmed send done");
        foreach (rows[i]) begin
            station <= rows[i].st;
            pair(rows[i].ad, rows[i].cm, rows[i].bad);
            chk("match count", rows[i].em, n_match);
            chk("strobe count", rows[i].es, n_strobe);
            if (rows[i].es == 8'h1) chk("command", {1'b0, rows[i].cm}, {1'b0, cmds[0]});
            $display("row %0d done", i);
        end
        station <= 7'h15;
        pair(7'h15, 7'h33, 2'h0);
        b1 <= 8'ha5;
        b2 <= 8'h3c;
        send <= 1'b1;
        fork
            begin
                master_inst.recv_word(d1, ok1);
                master_inst.recv_word(d2, ok2);
            end
            begin
                for (k = 0; k < 64 * BD && tx !== 1'b1; k++) @(posedge clock);
                b1 <= 8'h00;
                b2 <= 8'h00;
            end
        join
        @(posedge clock);
        chk("start delay", 8'h1, {7'h00, k >= BD / 2 && k <= 3 * BD / 2 + 6});
        chk("first byte", 8'ha5, d1);
        chk("second byte", 8'h3c, d2);
        chk("frame format", 8'h03, {6'h00, ok1, ok2});
        send <= 1'b0;
        repeat (2 * BD) @(posedge clock);
        n_tx = 8'h0;
        send <= 1'b1;
        repeat (30 * BD) @(posedge clock);
        chk("second send", 8'h00, n_tx);
        send <= 1'b0;
        $display("transmit done");
        ready <= 1'b0;
        pair(7'h15, 7'h11, 2'h0);
        master_inst.send_word(8'h95, 1'b0);
        master_inst.send_word(8'h12, 1'b0);
        pair(7'h15, 7'h13, 2'h0);
        chk("stalled strobes", 8'h00, n_strobe);
        ready <= 1'b1;
        repeat (4) @(posedge clock);
        chk("drained strobes", 8'h02, n_strobe);
        chk("first queued", 8'h11, {1'b0, cmds[0]});
        chk("second queued", 8'h12, {1'b0, cmds[1]});
        $display("buffer done");
        print_verdict();
    end
endmodule : tb
